//--- core/lgop_pkg.sv
// Package: opcodes, reset values and widths for the logical OR/AND unit
package lgop_pkg;
   localparam int LGOP_NREG = 8;
   localparam int LGOP_RW = 24;
   localparam int LGOP_IW = 16;
   // Instruction bit n counted from the left is instr[15-n]
   localparam logic [4:0] LGOP_OR_IMM = 5'h1A;
   localparam logic [4:0] LGOP_AND_IMM = 5'h1C;
   localparam logic [7:0] LGOP_OR_FULL = 8'hD8;
   localparam logic [7:0] LGOP_OR_HALF = 8'hD0;
   localparam logic [7:0] LGOP_OR_CHAR = 8'h58;
   localparam logic [7:0] LGOP_AND_FULL = 8'hE8;
   localparam logic [7:0] LGOP_AND_HALF = 8'hE0;
   localparam logic [7:0] LGOP_AND_CHAR = 8'h68;
   localparam logic [LGOP_RW-1:0] LGOP_REG_RST = 24'h000000;
   localparam logic [LGOP_RW-1:0] LGOP_BRANCH_RST = 24'h000000;
   typedef enum logic [2:0] {
      LGOP_NONE, LGOP_IMM, LGOP_CHR, LGOP_HALF, LGOP_FULL
   } lgop_form_t;
endpackage

//--- core/lgop_regfile.sv
// Register file: eight 24-bit general registers, registered read ports
`timescale 1ns/1ps
module lgop_regfile
   import lgop_pkg::*;
(
   input wire logic clk_i,                          // Clock
   input wire logic rst_i,                          // Async reset
   input wire logic [2:0] ra_i,                     // Read address A
   input wire logic [2:0] rb_i,                     // Read address B
   output logic [lgop_pkg::LGOP_RW-1:0] rda_o,      // Read data A
   output logic [lgop_pkg::LGOP_RW-1:0] rdb_o,      // Read data B
   input wire logic we_i,                           // Write enable
   input wire logic [2:0] wa_i,                     // Write address
   input wire logic [lgop_pkg::LGOP_RW-1:0] wd_i    // Write data
);
   import lgop_pkg::*;

   logic [LGOP_RW-1:0] mem_q [LGOP_NREG];
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < LGOP_NREG; i++)
            mem_q[i] <= LGOP_REG_RST;
         rda_o <= LGOP_REG_RST;
         rdb_o <= LGOP_REG_RST;
      end
      else
      begin
         if (we_i)
            mem_q[wa_i] <= wd_i;
         // Bypass so back-to-back instructions see the newest value
         rda_o <= (we_i && wa_i == ra_i) ? wd_i : mem_q[ra_i];
         rdb_o <= (we_i && wa_i == rb_i) ? wd_i : mem_q[rb_i];
      end
   end
endmodule

//--- core/lgop_exec.sv
// Execution datapath for bitwise OR and AND instructions
//
// Contract
// - Immediate OR ORs the 8-bit immediate into byte 0 or byte 1 of the register as the select bit says.
// - Immediate and character forms write only the selected byte and keep the other bytes.
// - Byte forms use the 2-bit register field as upper address bits with the low bit forced to one.
// - Character OR ORs the selected source byte into the selected destination byte of odd registers.
// - Full-register OR combines bytes 0, 1 and extension byte of source and destination.
// - Halfword OR and AND touch only bytes 0 and 1 and set latches from those bytes.
// - OR gives one where either operand bit is one, and every value is legal.
// - After a byte operation C is set when the result byte is nonzero and Z when it is zero.
// - After full-register OR or AND C is set when the result is nonzero and Z when zero.
// - Register 0 as destination in register or halfword forms branches to its value, latches kept.
// - Register-to-register forms never modify the source register.
// - Immediate AND ANDs the 8-bit immediate with byte 0 or byte 1 of the register.
// - AND gives one only where both operand bits are one.
// - Full-register AND ANDs all three bytes and stores the result in the destination.
`timescale 1ns/1ps
module lgop_exec
   import lgop_pkg::*;
(
   input wire logic clk_i,                              // Clock
   input wire logic rst_i,                              // Async reset
   input wire logic instr_valid_i,                      // Instruction strobe
   input wire logic [lgop_pkg::LGOP_IW-1:0] instr_i,    // Instruction word
   output logic busy_o,                                 // Executing
   output logic done_o,                                 // Result written
   output logic c_latch_o,                              // C latch
   output logic z_latch_o,                              // Z latch
   output logic branch_o,                               // Branch taken pulse
   output logic [lgop_pkg::LGOP_RW-1:0] branch_addr_o,  // Branch target
   output logic illegal_o,                              // Not an OR/AND form
   output logic [lgop_pkg::LGOP_RW-1:0] wr_data_o,      // Last written value
   output logic [2:0] wr_addr_o                         // Last written reg
);
   import lgop_pkg::*;

   typedef enum logic [1:0] {LGOP_IDLE, LGOP_READ, LGOP_EXEC} lgop_state_t;

   typedef struct packed {
      lgop_state_t st;
      lgop_form_t form;
      logic is_and;
      logic [2:0] dst;
      logic [2:0] src;
      logic dsel;
      logic ssel;
      logic [7:0] imm;
      logic c;
      logic z;
      logic busy;
      logic done;
      logic branch;
      logic [LGOP_RW-1:0] baddr;
      logic illegal;
      logic [LGOP_RW-1:0] wdata;
      logic [2:0] waddr;
   } lgop_st_t;

   lgop_st_t s_q, s_d;
   logic [LGOP_RW-1:0] rda, rdb;
   logic we;
   logic [LGOP_RW-1:0] wd;

   // Bitwise combine shared by all forms
   function automatic logic [LGOP_RW-1:0] lgop_combine(
      input logic is_and,
      input logic [LGOP_RW-1:0] a,
      input logic [LGOP_RW-1:0] b);
      lgop_combine = is_and ? (a & b) : (a | b);
   endfunction

   function automatic logic [7:0] lgop_byte(
      input logic [LGOP_RW-1:0] r,
      input logic sel);
      lgop_byte = sel ? r[15:8] : r[7:0];
   endfunction

   lgop_regfile u_rf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ra_i(s_q.dst),
      .rb_i(s_q.src),
      .rda_o(rda),
      .rdb_o(rdb),
      .we_i(we),
      .wa_i(s_q.dst),
      .wd_i(wd)
   );

   always_comb
   begin
      logic [7:0] res8;
      logic [LGOP_RW-1:0] full;
      logic [LGOP_RW-1:0] merged;
      res8 = 8'h00;
      full = '0;
      merged = rda;
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.branch = 1'b0;
      s_d.illegal = 1'b0;
      we = 1'b0;
      wd = rda;
      case (s_q.st)
         LGOP_IDLE:
         begin
            if (instr_valid_i)
            begin
               s_d.form = LGOP_NONE;
               s_d.imm = instr_i[7:0];
               s_d.dsel = instr_i[8];
               s_d.ssel = instr_i[12];
               s_d.src = instr_i[14:12];
               s_d.dst = instr_i[10:8];
               s_d.is_and = 1'b0;
               if (instr_i[15:11] == LGOP_OR_IMM ||
                   instr_i[15:11] == LGOP_AND_IMM)
               begin
                  s_d.form = LGOP_IMM;
                  s_d.is_and = (instr_i[15:11] == LGOP_AND_IMM);
                  s_d.dst = {instr_i[10:9], 1'b1};
               end
               else if (instr_i[15] == 1'b0 && instr_i[11] == 1'b0)
               begin
                  case (instr_i[7:0])
                     LGOP_OR_FULL, LGOP_AND_FULL:
                        s_d.form = LGOP_FULL;
                     LGOP_OR_HALF, LGOP_AND_HALF:
                        s_d.form = LGOP_HALF;
                     LGOP_OR_CHAR, LGOP_AND_CHAR:
                        s_d.form = LGOP_CHR;
                     default:
                        s_d.form = LGOP_NONE;
                  endcase
                  s_d.is_and = instr_i[5];
                  if (s_d.form == LGOP_CHR)
                  begin
                     s_d.dst = {instr_i[10:9], 1'b1};
                     s_d.src = {instr_i[14:13], 1'b1};
                  end
               end
               if (s_d.form == LGOP_NONE)
                  s_d.illegal = 1'b1;
               else
               begin
                  s_d.st = LGOP_READ;
                  s_d.busy = 1'b1;
               end
            end
         end
         LGOP_READ:
            s_d.st = LGOP_EXEC;
         LGOP_EXEC:
         begin
            s_d.st = LGOP_IDLE;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            we = 1'b1;
            case (s_q.form)
               LGOP_IMM, LGOP_CHR:
               begin
                  full = lgop_combine(s_q.is_and, {16'h0000,
                     lgop_byte(rda, s_q.dsel)},
                     {16'h0000, (s_q.form == LGOP_IMM) ? s_q.imm
                     : lgop_byte(rdb, s_q.ssel)});
                  res8 = full[7:0];
                  if (s_q.dsel)
                     merged[15:8] = res8;
                  else
                     merged[7:0] = res8;
                  wd = merged;
                  s_d.c = (res8 != 8'h00);
                  s_d.z = (res8 == 8'h00);
               end
               default:
               begin
                  // Source is read only; only the destination is written
                  full = lgop_combine(s_q.is_and, rda, rdb);
                  if (s_q.form == LGOP_HALF)
                     wd = {rda[23:16], full[15:0]};
                  else
                     wd = full;
                  if (s_q.dst == 3'h0)
                  begin
                     // Result lands in register 0 and is taken as target
                     s_d.branch = 1'b1;
                     s_d.baddr = wd;
                  end
                  else if (s_q.form == LGOP_HALF)
                  begin
                     s_d.c = (wd[15:0] != 16'h0000);
                     s_d.z = (wd[15:0] == 16'h0000);
                  end
                  else
                  begin
                     s_d.c = (wd != '0);
                     s_d.z = (wd == '0);
                  end
               end
            endcase
            s_d.wdata = wd;
            s_d.waddr = s_q.dst;
         end
         default:
            s_d.st = LGOP_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
         s_q.st <= LGOP_IDLE;
         s_q.form <= LGOP_NONE;
         s_q.baddr <= LGOP_BRANCH_RST;
      end
      else
         s_q <= s_d;
   end

   assign busy_o = s_q.busy;
   assign done_o = s_q.done;
   assign c_latch_o = s_q.c;
   assign z_latch_o = s_q.z;
   assign branch_o = s_q.branch;
   assign branch_addr_o = s_q.baddr;
   assign illegal_o = s_q.illegal;
   assign wr_data_o = s_q.wdata;
   assign wr_addr_o = s_q.waddr;
endmodule

//--- tb/lgop_exec_asserts.sv
// Port checker for the OR/AND execution unit
`timescale 1ns/1ps
module lgop_exec_asserts
   import lgop_pkg::*;
(
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic instr_valid_i, // Strobe
   input wire logic [LGOP_IW-1:0] instr_i, // Word
   input wire logic busy_o, // Busy
   input wire logic done_o, // Done
   input wire logic c_latch_o, // C
   input wire logic z_latch_o, // Z
   input wire logic branch_o, // Branch
   input wire logic [LGOP_RW-1:0] branch_addr_o, // Target
   input wire logic illegal_o, // Illegal
   input wire logic [LGOP_RW-1:0] wr_data_o, // Data
   input wire logic [2:0] wr_addr_o // Reg
);
   logic [15:0] ins_q;
   logic bf;
   logic hf;
   default clocking
      @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Refused strobes must not disturb the word being judged
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
         ins_q <= 16'h0000;
      else if (instr_valid_i && !busy_o)
         ins_q <= instr_i;
   assign bf = ins_q[15] | ~ins_q[7];
   assign hf = ~ins_q[15] & ins_q[7] & ~ins_q[3];
   property p_done_lat;
      $rose(busy_o) |-> ##2 done_o;
   endproperty
   a_done_lat: assert property (p_done_lat)
      else $error("done late");
   property p_byte_c;
      done_o && bf |->
         c_latch_o == |(ins_q[8] ? wr_data_o[15:8] : wr_data_o[7:0]);
   endproperty
   a_byte_c: assert property (p_byte_c)
      else $error("byte C wrong");
   property p_half_c;
      done_o && hf && !branch_o |-> c_latch_o == |wr_data_o[15:0];
   endproperty
   a_half_c: assert property (p_half_c)
      else $error("half C wrong");
   property p_full_c;
      done_o && !bf && !hf && !branch_o |-> c_latch_o == |wr_data_o;
   endproperty
   a_full_c: assert property (p_full_c)
      else $error("full C wrong");
   property p_addr;
      done_o && bf |-> wr_addr_o == {ins_q[10:9], 1'h1};
   endproperty
   a_addr: assert property (p_addr)
      else $error("byte reg wrong");
   property p_br;
      done_o && !bf && ins_q[10:8] == 3'h0 |-> branch_o &&
         branch_addr_o == wr_data_o && $stable(c_latch_o) &&
         $stable(z_latch_o);
   endproperty
   a_br: assert property (p_br)
      else $error("branch wrong");
   property p_hold;
      !done_o |-> $stable(c_latch_o) && $stable(z_latch_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("latch moved");
   property p_cz;
      done_o && !branch_o |-> c_latch_o ^ z_latch_o;
   endproperty
   a_cz: assert property (p_cz)
      else $error("C and Z agree");
   property p_ill;
      illegal_o |-> !done_o ##1 !illegal_o;
   endproperty
   a_ill: assert property (p_ill)
      else $error("illegal pulse wrong");
   c_br: cover property (done_o && branch_o);
   c_ill: cover property (illegal_o);
   c_byte: cover property (done_o && bf && z_latch_o);
endmodule

//--- tb/test_logical_or_and_execute.sv
// Self-checking bench for the OR/AND execution unit
`timescale 1ns/1ps
module test_logical_or_and_execute;
   import lgop_pkg::*;
   typedef struct packed {
      logic [15:0] ins;
      logic [23:0] wd;
      logic [2:0] wa;
      logic c;
      logic br;
   } lgop_row_t;
   logic clk_i, rst_i, instr_valid_i, busy_o, done_o, c_latch_o;
   logic z_latch_o, branch_o, illegal_o;
   logic [15:0] instr_i;
   logic [23:0] branch_addr_o, wr_data_o;
   logic [2:0] wr_addr_o;
   int err_count, checked;
   lgop_row_t rows [12];
   lgop_exec u_dut (.clk_i, .rst_i, .instr_valid_i, .instr_i, .busy_o,
      .done_o, .c_latch_o, .z_latch_o, .branch_o, .branch_addr_o,
      .illegal_o, .wr_data_o, .wr_addr_o);
   function automatic logic [15:0] ri(logic [4:0] o, logic [1:0] r,
      logic n, logic [7:0] d);
      return {o, r, n, d};
   endfunction
   function automatic logic [15:0] rr(logic [2:0] s, logic [2:0] t,
      logic [7:0] o);
      return {1'h0, s, 1'h0, t, o};
   endfunction
   task automatic chk(string nm, logic [23:0] e, logic [23:0] s);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic run(logic [15:0] ins);
      int n;
      instr_i = ins;
      instr_valid_i = 1'h1;
      @(posedge clk_i);
      #1 instr_valid_i = 1'h0;
      chk("busy", 24'h1, 24'(busy_o));
      n = 0;
      while (done_o !== 1'h1 && n < 8)
      begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("done", 24'h1, 24'(done_o));
      chk("idle", 24'h0, 24'(busy_o));
   endtask
   task automatic results;
      $display("Counts: %0d checked, %0d errors", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end
   initial
   begin
      #5000 err_count++;
      results();
   end
   initial
   begin
      rows[0]='{ri(LGOP_OR_IMM,2'h1,1'h0,8'h5A),24'h00005A,3'h3,1'h1,1'h0};
      rows[1]='{ri(LGOP_OR_IMM,2'h1,1'h1,8'hA5),24'h00A55A,3'h3,1'h1,1'h0};
      rows[2]='{ri(LGOP_AND_IMM,2'h1,1'h1,8'h0F),24'h00055A,3'h3,1'h1,1'h0};
      rows[3]='{ri(LGOP_OR_IMM,2'h0,1'h0,8'h80),24'h000080,3'h1,1'h1,1'h0};
      rows[4]='{rr(3'h0,3'h3,LGOP_OR_CHAR),24'h00855A,3'h3,1'h1,1'h0};
      rows[5]='{rr(3'h3,3'h1,LGOP_OR_FULL),24'h0085DA,3'h1,1'h1,1'h0};
      rows[6]='{rr(3'h1,3'h2,LGOP_OR_HALF),24'h0085DA,3'h2,1'h1,1'h0};
      rows[7]='{rr(3'h3,3'h2,LGOP_AND_FULL),24'h00855A,3'h2,1'h1,1'h0};
      rows[8]='{rr(3'h5,3'h1,LGOP_AND_HALF),24'h000000,3'h1,1'h0,1'h0};
      rows[9]='{rr(3'h5,3'h3,LGOP_AND_CHAR),24'h00005A,3'h3,1'h0,1'h0};
      rows[10]='{rr(3'h2,3'h0,LGOP_OR_FULL),24'h00855A,3'h0,1'h0,1'h1};
      rows[11]='{rr(3'h3,3'h0,LGOP_AND_HALF),24'h00005A,3'h0,1'h0,1'h1};
      rst_i = 1'h1;
      instr_valid_i = 1'h0;
      instr_i = 16'h0000;
      repeat (4) @(posedge clk_i);
      #1 rst_i = 1'h0;
      foreach (rows[i])
      begin
         run(rows[i].ins);
         chk("wr_data", rows[i].wd, wr_data_o);
         chk("wr_addr", 24'(rows[i].wa), 24'(wr_addr_o));
         chk("c", 24'(rows[i].c), 24'(c_latch_o));
         chk("z", 24'(!rows[i].c), 24'(z_latch_o));
         chk("branch", 24'(rows[i].br), 24'(branch_o));
      end
      chk("target", 24'h00005A, branch_addr_o);
      $display("Table rows done");
      // A strobe during busy must leave register 7 byte 1 alone
      instr_i = ri(LGOP_OR_IMM, 2'h3, 1'h0, 8'h11);
      instr_valid_i = 1'h1;
      @(posedge clk_i);
      #1 instr_i = ri(LGOP_OR_IMM, 2'h3, 1'h1, 8'hFF);
      @(posedge clk_i);
      #1 instr_valid_i = 1'h0;
      repeat (2) @(posedge clk_i);
      #1 run(ri(LGOP_OR_IMM, 2'h3, 1'h1, 8'h00));
      chk("refused", 24'h000011, wr_data_o);
      $display("Refusal test done");
      instr_i = 16'h0000;
      instr_valid_i = 1'h1;
      @(posedge clk_i);
      #1 instr_valid_i = 1'h0;
      // Illegal flag is a one-cycle pulse, so look right after the edge
      chk("illegal", 24'h1, 24'(illegal_o));
      rst_i = 1'h1;
      @(posedge clk_i);
      #1 rst_i = 1'h0;
      chk("rst target", 24'h0, branch_addr_o);
      chk("rst data", 24'h0, wr_data_o);
      run(ri(LGOP_OR_IMM, 2'h3, 1'h1, 8'h00));
      chk("rst reg", 24'h0, wr_data_o);
      chk("rst z", 24'h1, 24'(z_latch_o));
      $display("Illegal and reset tests done");
      results();
   end
endmodule
bind lgop_exec lgop_exec_asserts u_chk (.clk_i, .rst_i, .instr_valid_i,
   .instr_i, .busy_o, .done_o, .c_latch_o, .z_latch_o, .branch_o,
   .branch_addr_o, .illegal_o, .wr_data_o, .wr_addr_o);
